// File: logic/dcke_pkg.sv
`default_nettype none
package dcke_pkg;
    // Command encoding {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP      = 4'h7;
    localparam logic [3:0] CMD_REFRESH  = 4'h1;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_PRECHG   = 4'h2;
    localparam logic [3:0] CMD_WRITE    = 4'h4;
    localparam logic [3:0] CMD_READ     = 4'h5;
    localparam logic [3:0] CMD_MRS      = 4'h0;
    localparam logic [3:0] CMD_DESELECT = 4'h8;
    // Timing counts in link clocks
    localparam int CKE_MIN_CLOCKS       = 3;
    localparam int READ_EXIT_CLOCKS     = 200;
    localparam int NONREAD_EXIT_CLOCKS  = 10;
    localparam int PD_EXIT_CLOCKS       = 2;
    // Link clock divider: half period in ref_clk cycles
    localparam int CLK_HALF_DIV         = 6;
    // Widths
    localparam int DATA_W               = 8;
    localparam int ADDR_W               = 4;
    localparam int CNT_W                = 9;
    typedef enum logic [2:0] {
        DCKE_IDLE     = 3'b000,
        DCKE_ACTIVE   = 3'b001,
        DCKE_PRE_PD   = 3'b010,
        DCKE_ACT_PD   = 3'b011,
        DCKE_SELF_REF = 3'b100
    } dcke_state_t;

    function automatic logic is_nop_or_desel(input logic [3:0] cmd);
        return cmd[3] || (cmd == CMD_NOP);
    endfunction
endpackage
`default_nettype wire

// File: logic/dcke_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcke_if;
    logic                          clk_link;
    logic                          cke;
    logic                          cs_n;
    logic                          ras_n;
    logic                          cas_n;
    logic                          we_n;
    logic [dcke_pkg::ADDR_W-1:0]   addr;
    logic [dcke_pkg::DATA_W-1:0]   wdata;
    logic                          write_mask_input;
    logic                          termination_enable_input;
    modport ctrl (
        output clk_link, cke, cs_n, ras_n, cas_n, we_n, addr, wdata,
        output write_mask_input, termination_enable_input
    );
    modport mem (
        input clk_link, cke, cs_n, ras_n, cas_n, we_n, addr, wdata,
        input write_mask_input, termination_enable_input
    );
endinterface
`default_nettype wire

// File: logic/dcke_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcke_edge_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Pins
    input  wire logic         link_clk,
    input  wire logic [W-1:0] pins,
    // Synchronised outputs
    output logic              rise,
    output logic [W-1:0]      pins_sync
);
    logic [W:0] stage1;
    logic [W:0] stage2;
    logic       clk_prev;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1   <= '0;
            stage2   <= '0;
            clk_prev <= 1'b0;
        end else begin
            stage1   <= {link_clk, pins};
            stage2   <= stage1;
            clk_prev <= stage2[W];
        end
    end
    assign rise      = stage2[W] & ~clk_prev;
    assign pins_sync = stage2[W-1:0];
endmodule // dcke_edge_sync
`default_nettype wire

// File: logic/dcke_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dcke_mem #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Link
    dcke_if.mem                              link,
    // Status
    output logic [2:0]                       power_state,
    output logic                             termination_active,
    output logic [dcke_pkg::DATA_W-1:0]      last_stored,
    output logic                             store_strobe
);
    localparam int PW = 1 + 4 + dcke_pkg::ADDR_W + dcke_pkg::DATA_W + 2;
    logic                          rise;
    logic [PW-1:0]                 p;
    logic [dcke_pkg::DATA_W-1:0]   array_mem [DEPTH];
    dcke_pkg::dcke_state_t         state;
    dcke_pkg::dcke_state_t         next_state;
    logic                          cke_prev;
    logic                          store_pend;
    logic [dcke_pkg::ADDR_W-1:0]   store_addr;

    dcke_edge_sync #(.W(PW)) u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .link_clk  (link.clk_link),
        .pins      ({link.cke, link.cs_n, link.ras_n, link.cas_n,
                     link.we_n, link.addr, link.wdata,
                     link.write_mask_input,
                     link.termination_enable_input}),
        .rise      (rise),
        .pins_sync (p)
    );

    // Field extraction
    wire                        cke_now = p[PW-1];
    wire [3:0]                  cmd     = p[PW-2:PW-5];
    wire [dcke_pkg::ADDR_W-1:0] addr_s  = p[PW-6 -: dcke_pkg::ADDR_W];
    wire [dcke_pkg::DATA_W-1:0] data_s  =
        p[dcke_pkg::DATA_W+1:2];
    wire                        mask_s  = p[1];
    wire                        term_s  = p[0];

    // Command decode; deselect makes the strobes don't care
    wire [3:0] cmd_cs   = cmd[3] ? dcke_pkg::CMD_DESELECT : cmd;
    wire       nop_like = dcke_pkg::is_nop_or_desel(cmd);
    wire       is_ref   = (cmd_cs == dcke_pkg::CMD_REFRESH);
    wire       is_act   = (cmd_cs == dcke_pkg::CMD_ACTIVATE);
    wire       is_pre   = (cmd_cs == dcke_pkg::CMD_PRECHG);
    wire       is_wr    = (cmd_cs == dcke_pkg::CMD_WRITE);

    // Clock enable at the previous and at this edge
    wire       cke_fall = cke_prev && !cke_now;
    wire       cke_rise = !cke_prev && cke_now;
    wire       cke_high = cke_prev && cke_now;
    wire       cke_low  = !cke_prev && !cke_now;

    // State classes and write qualification
    wire       in_sr     = (state == dcke_pkg::DCKE_SELF_REF);
    wire       low_pwr   = (state == dcke_pkg::DCKE_PRE_PD) ||
                           (state == dcke_pkg::DCKE_ACT_PD) || in_sr;
    wire       do_write  = (state == dcke_pkg::DCKE_ACTIVE) &&
                           cke_high && is_wr;
    wire       do_store  = do_write && !mask_s;
    wire       store_now = rise && do_store;

    // Transition decode; termination level takes no part
    always_comb begin
        next_state = state;
        case (state)
            dcke_pkg::DCKE_IDLE: begin
                if (cke_fall && nop_like) begin
                    next_state = dcke_pkg::DCKE_PRE_PD;
                end else if (cke_fall && is_ref) begin
                    next_state = dcke_pkg::DCKE_SELF_REF;
                end else if (cke_high && is_act) begin
                    next_state = dcke_pkg::DCKE_ACTIVE;
                end
            end

            dcke_pkg::DCKE_ACTIVE: begin
                if (cke_fall && nop_like) begin
                    next_state = dcke_pkg::DCKE_ACT_PD;
                end else if (cke_high && is_pre) begin
                    next_state = dcke_pkg::DCKE_IDLE;
                end
            end

            dcke_pkg::DCKE_PRE_PD: begin
                if (cke_rise && nop_like) begin
                    next_state = dcke_pkg::DCKE_IDLE;
                end
            end

            dcke_pkg::DCKE_ACT_PD: begin
                if (cke_rise && nop_like) begin
                    next_state = dcke_pkg::DCKE_ACTIVE;
                end
            end

            dcke_pkg::DCKE_SELF_REF: begin
                if (cke_rise && nop_like) begin
                    next_state = dcke_pkg::DCKE_IDLE;
                end
            end

            default: begin
                next_state = dcke_pkg::DCKE_IDLE;
            end
        endcase
        if (low_pwr && cke_low) begin
            next_state = state;
        end
    end

    // Sample only on link clock rising edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state    <= dcke_pkg::DCKE_IDLE;
            cke_prev <= 1'b0;
        end else if (rise) begin
            state    <= next_state;
            cke_prev <= cke_now;
        end
    end

    // Masked beats never reach the array
    always_ff @(posedge ref_clk) begin
        if (store_now) begin
            array_mem[addr_s] <= data_s;
        end
    end

    // Remember where the last beat went, read back a cycle later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            store_pend <= 1'b0;
            store_addr <= '0;
        end else begin
            store_pend <= store_now;
            if (store_now) begin
                store_addr <= addr_s;
            end
        end
    end

    // Power state mirror
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_state <= 3'h0;
        end else begin
            power_state <= state;
        end
    end

    // Termination follows its input outside self refresh
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            termination_active <= 1'b0;
        end else begin
            termination_active <= term_s && !in_sr;
        end
    end

    // Stored word taken back out of the array
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_stored  <= '0;
            store_strobe <= 1'b0;
        end else begin
            store_strobe <= store_pend;
            if (store_pend) begin
                last_stored <= array_mem[store_addr];
            end
        end
    end
endmodule // dcke_mem
`default_nettype wire

// File: logic/dcke_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dcke_ctrl #(
    parameter int NONREAD_EXIT = dcke_pkg::NONREAD_EXIT_CLOCKS,
    parameter int PD_EXIT      = dcke_pkg::PD_EXIT_CLOCKS
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // User requests, one-cycle pulses
    input  wire logic                      req_activate,
    input  wire logic                      req_precharge,
    input  wire logic                      req_write,
    input  wire logic                      req_read,
    input  wire logic                      req_power_down,
    input  wire logic                      req_self_refresh,
    input  wire logic                      req_wake,
    input  wire logic                      req_odt,
    input  wire logic                      req_mask,
    input  wire logic [dcke_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [dcke_pkg::DATA_W-1:0] req_data,
    // Status
    output logic                           busy,
    output logic                           read_allowed,
    // Link
    dcke_if.ctrl                           link
);
    logic [3:0]                    div_cnt;
    logic                          clk_q;
    logic [dcke_pkg::CNT_W-1:0]    wait_cnt;
    logic [dcke_pkg::CNT_W-1:0]    read_cnt;
    logic [1:0]                    cke_run;
    logic                          cke_q;
    logic                          lowp;
    logic [3:0]                    cmd_q;
    logic                          pend;
    logic [3:0]                    pend_cmd;
    logic                          pend_cke;
    logic                          odt_q;
    logic                          odt_req;
    logic                          mask_q;
    logic [dcke_pkg::ADDR_W-1:0]   addr_q;
    logic [dcke_pkg::DATA_W-1:0]   data_q;

    wire fall   = (div_cnt == 4'(dcke_pkg::CLK_HALF_DIV - 1)) && clk_q;
    wire run_ok = (cke_run == 2'(dcke_pkg::CKE_MIN_CLOCKS - 1));
    wire idle_ok = (wait_cnt == '0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt <= 4'h0;
            clk_q   <= 1'b0;
        end else if (div_cnt == 4'(dcke_pkg::CLK_HALF_DIV - 1)) begin
            div_cnt <= 4'h0;
            clk_q   <= ~clk_q;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // Pending request capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend     <= 1'b0;
            pend_cmd <= dcke_pkg::CMD_DESELECT;
            pend_cke <= 1'b1;
            addr_q   <= '0;
            data_q   <= '0;
            mask_q   <= 1'b0;
        end else if (!pend && !busy) begin
            pend     <= req_activate | req_precharge | req_write |
                        (req_read & read_allowed) | req_power_down |
                        req_self_refresh | req_wake;
            pend_cmd <= req_activate  ? dcke_pkg::CMD_ACTIVATE :
                        req_precharge ? dcke_pkg::CMD_PRECHG :
                        req_write     ? dcke_pkg::CMD_WRITE :
                        req_read      ? dcke_pkg::CMD_READ :
                        req_self_refresh ? dcke_pkg::CMD_REFRESH :
                        dcke_pkg::CMD_NOP;
            pend_cke <= !(req_power_down | req_self_refresh);
            addr_q   <= req_addr;
            data_q   <= req_data;
            mask_q   <= req_mask;
        end else if (fall && pend && idle_ok &&
                     (pend_cke == cke_q || run_ok)) begin
            pend <= 1'b0;
        end
    end

    // Termination request latched on its pulse and held until reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            odt_req <= 1'b0;
        end else if (req_odt) begin
            odt_req <= 1'b1;
        end
    end

    // Command launch on falling link edge
    wire launch = fall && pend && idle_ok &&
                  (pend_cke == cke_q || run_ok);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cke_q    <= 1'b0;
            cmd_q    <= dcke_pkg::CMD_DESELECT;
            cke_run  <= 2'h0;
            lowp     <= 1'b0;
            wait_cnt <= '0;
            read_cnt <= '0;
            odt_q    <= 1'b0;
        end else if (fall) begin
            odt_q <= odt_req | odt_q;
            if (launch) begin
                cke_q   <= pend_cke;
                cmd_q   <= pend_cmd;
                cke_run <= (pend_cke != cke_q) ? 2'h0 : cke_run;
                lowp    <= !pend_cke;
                if (lowp && pend_cke) begin
                    wait_cnt <= (pend_cmd == dcke_pkg::CMD_REFRESH) ?
                        dcke_pkg::CNT_W'(NONREAD_EXIT) :
                        dcke_pkg::CNT_W'(PD_EXIT);
                    read_cnt <= dcke_pkg::CNT_W'(dcke_pkg::READ_EXIT_CLOCKS);
                end else if (pend_cmd == dcke_pkg::CMD_WRITE ||
                             pend_cmd == dcke_pkg::CMD_READ ||
                             pend_cmd == dcke_pkg::CMD_PRECHG) begin
                    wait_cnt <= dcke_pkg::CNT_W'(4);
                end
            end else begin
                cmd_q <= dcke_pkg::CMD_DESELECT;
                if (!run_ok)
                    cke_run <= cke_run + 2'h1;
                if (wait_cnt != '0)
                    wait_cnt <= wait_cnt - 1'b1;
                if (read_cnt != '0)
                    read_cnt <= read_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy         <= 1'b0;
            read_allowed <= 1'b0;
        end else begin
            busy         <= pend;
            read_allowed <= (read_cnt == '0) && !lowp;
        end
    end

    always_comb begin
        link.clk_link                 = clk_q;
        link.cke                      = cke_q;
        link.cs_n                     = cmd_q[3];
        link.ras_n                    = cmd_q[3] | cmd_q[2];
        link.cas_n                    = cmd_q[3] | cmd_q[1];
        link.we_n                     = cmd_q[3] | cmd_q[0];
        link.addr                     = addr_q;
        link.wdata                    = data_q;
        link.write_mask_input         = mask_q;
        link.termination_enable_input = odt_q;
    end
endmodule // dcke_ctrl
`default_nettype wire

// File: tb/dcke_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcke_link_assertions #(
    parameter int NONREAD_EXIT = dcke_pkg::NONREAD_EXIT_CLOCKS,
    parameter int PD_EXIT      = dcke_pkg::PD_EXIT_CLOCKS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link pins
    input wire logic clk_link,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n
);
    logic       clk_d, cke_p, low, in_sr, from_sr, open_bank;
    logic [8:0] run, since_x, since_op;
    wire  [3:0] cmd  = {cs_n, ras_n, cas_n, we_n};
    wire        lr   = clk_link & ~clk_d;
    wire        nop  = cmd[3] | (cmd == dcke_pkg::CMD_NOP);
    wire        c_up = lr & cke & ~cke_p;
    wire        c_dn = lr & ~cke & cke_p;
    wire        refr = cmd == dcke_pkg::CMD_REFRESH;
    wire        rw   = cmd == dcke_pkg::CMD_WRITE || cmd == dcke_pkg::CMD_READ;
    wire        op   = rw || cmd == dcke_pkg::CMD_PRECHG;
    // Link edge, clock enable history and low power tracking
    always_ff @(posedge ref_clk) begin
        clk_d <= rst ? 1'b0 : clk_link;
        if (rst) cke_p <= 1'b0;
        else if (lr) cke_p <= cke;
        if (rst || c_up) low <= 1'b0;
        else if (c_dn) low <= 1'b1;
        if (rst || c_up) in_sr <= 1'b0;
        else if (c_dn && refr) in_sr <= 1'b1;
        if (rst) from_sr <= 1'b0;
        else if (c_up && low) from_sr <= in_sr;
        if (rst) open_bank <= 1'b0;
        else if (lr && cmd == dcke_pkg::CMD_ACTIVATE) open_bank <= 1'b1;
        else if (lr && cmd == dcke_pkg::CMD_PRECHG) open_bank <= 1'b0;
    end
    // Link clock counters
    always_ff @(posedge ref_clk) begin
        if (rst) run <= 9'h1ff;
        else if (c_up || c_dn) run <= 9'h001;
        else if (lr && run != 9'h1ff) run <= run + 9'h001;
        if (rst) since_x <= 9'h1ff;
        else if (c_up && low) since_x <= 9'h000;
        else if (lr && since_x != 9'h1ff) since_x <= since_x + 9'h001;
        if (rst) since_op <= 9'h1ff;
        else if (lr && op) since_op <= 9'h000;
        else if (lr && since_op != 9'h1ff) since_op <= since_op + 9'h001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_EXIT_IDLE_CMD: assert property (c_up |-> nop)
        else $error("Busy command at clock enable rise");
    AST_ENTRY_CMD: assert property (c_dn |-> nop || refr)
        else $error("Bad command at clock enable fall");
    AST_SR_FROM_IDLE: assert property (c_dn && refr |-> !open_bank)
        else $error("Self refresh entry with a bank open");
    AST_CKE_MIN: assert property ((c_up || c_dn) |->
        run >= dcke_pkg::CKE_MIN_CLOCKS)
        else $error("Clock enable level too short");
    AST_SR_QUIET: assert property (
        lr && from_sr && since_x < NONREAD_EXIT |-> nop)
        else $error("Command inside self refresh exit delay");
    AST_SR_NO_READ: assert property (
        lr && from_sr && since_x < dcke_pkg::READ_EXIT_CLOCKS
        |-> cmd != dcke_pkg::CMD_READ)
        else $error("Read inside read exit delay");
    AST_PD_EXIT_WAIT: assert property (
        lr && !from_sr && since_x < PD_EXIT |-> nop)
        else $error("Command inside power down exit latency");
    AST_LOW_DESELECT: assert property (lr && !cke && !cke_p |-> cmd[3])
        else $error("Command while clock enable stays low");
    AST_OP_SETTLED: assert property (c_dn |-> since_op >= 9'h002)
        else $error("Low power entry during an operation");
    AST_RW_OPEN: assert property (lr && cke && cke_p && rw |-> open_bank)
        else $error("Access without an open bank");
endmodule // dcke_link_assertions
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int ACT = 0, PRE = 1, WR = 2, RD = 3;
    localparam int PD = 4, SR = 5, WK = 6, TERMINATION_ENABLE_INPUT = 7;
    logic       ref_clk, rst, busy, read_allowed, store_strobe, term_on;
    logic       mask;
    logic [7:0] rq, data, last_stored;
    logic [3:0] addr;
    logic [2:0] power_state;
    int         n_errors, n_compared, n_store, n0, j;
    dcke_if dcke_if_i ();
    dcke_ctrl #(.NONREAD_EXIT(10), .PD_EXIT(2)) dcke_ctrl_i (
        .ref_clk(ref_clk), .rst(rst), .req_activate(rq[ACT]),
        .req_precharge(rq[PRE]), .req_write(rq[WR]), .req_read(rq[RD]),
        .req_power_down(rq[PD]), .req_self_refresh(rq[SR]),
        .req_wake(rq[WK]), .req_odt(rq[TERMINATION_ENABLE_INPUT]), .req_mask(mask),
        .req_addr(addr), .req_data(data), .busy(busy),
        .read_allowed(read_allowed), .link(dcke_if_i.ctrl));
    dcke_mem dcke_mem_i (
        .ref_clk(ref_clk), .rst(rst), .link(dcke_if_i.mem),
        .power_state(power_state), .termination_active(term_on),
        .last_stored(last_stored), .store_strobe(store_strobe));
    dcke_link_assertions #(.NONREAD_EXIT(10), .PD_EXIT(2))
        dcke_link_assertions_i (
        .ref_clk(ref_clk), .rst(rst), .clk_link(dcke_if_i.clk_link),
        .cke(dcke_if_i.cke), .cs_n(dcke_if_i.cs_n),
        .ras_n(dcke_if_i.ras_n), .cas_n(dcke_if_i.cas_n),
        .we_n(dcke_if_i.we_n));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One request pulse, then wait for the command to reach the memory
    task automatic issue(input int k, input logic [7:0] d, input logic m);
        int w;
        for (w = 0; w < 400 && busy !== 1'b0; w++) step(1);
        rq[k] = 1'b1;
        data = d;
        addr = d[3:0];
        mask = m;
        step(1);
        rq = 8'h00;
        step(1);
        for (w = 0; w < 400 && busy !== 1'b0; w++) step(1);
        step(30);
    endtask
    task automatic results;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (store_strobe === 1'b1) n_store++;
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #150000;
        n_errors++;
        results;
    end
    initial begin
        rst = 1'b1;
        rq = 8'h00;
        data = 8'h00;
        addr = 4'h0;
        mask = 1'b0;
        n_errors = 0;
        n_compared = 0;
        n_store = 0;
        step(3);
        rst = 1'b0;
        step(1);
        check("reset state", 8'(power_state), 8'h00);
        issue(WK, 8'h00, 1'b0);
        issue(ACT, 8'h01, 1'b0);
        check("activated", 8'(power_state), 8'h01);
        n0 = n_store;
        issue(WR, 8'ha5, 1'b0);
        check("stores", 8'(n_store - n0), 8'h01);
        check("stored data", last_stored, 8'ha5);
        issue(WR, 8'h3c, 1'b1);
        check("masked stores", 8'(n_store - n0), 8'h01);
        check("masked data", last_stored, 8'ha5);
        issue(TERMINATION_ENABLE_INPUT, 8'h00, 1'b0);
        check("termination on", 8'(term_on), 8'h01);
        issue(PD, 8'h00, 1'b0);
        check("active pd", 8'(power_state), 8'h03);
        step(100);
        check("pd held", 8'(power_state), 8'h03);
        issue(WK, 8'h00, 1'b0);
        check("pd exit", 8'(power_state), 8'h01);
        issue(PRE, 8'h00, 1'b0);
        check("precharged", 8'(power_state), 8'h00);
        issue(PD, 8'h00, 1'b0);
        check("precharge pd", 8'(power_state), 8'h02);
        issue(WK, 8'h00, 1'b0);
        check("idle again", 8'(power_state), 8'h00);
        issue(SR, 8'h00, 1'b0);
        check("self refresh", 8'(power_state), 8'h04);
        check("termination off", 8'(term_on), 8'h00);
        issue(WK, 8'h00, 1'b0);
        check("sr exit", 8'(power_state), 8'h00);
        check("read held", 8'(read_allowed), 8'h00);
        for (j = 0; j < 4000 && read_allowed !== 1'b1; j++) step(1);
        check("read wait", 8'(j >= dcke_pkg::READ_EXIT_CLOCKS * 2 *
            dcke_pkg::CLK_HALF_DIV - 100), 8'h01);
        issue(ACT, 8'h02, 1'b0);
        issue(RD, 8'h02, 1'b0);
        check("after read", 8'(power_state), 8'h01);
        results;
    end
endmodule // testbench
`default_nettype wire
